/* hw/plc_pkg.sv */
// Purpose: shared constants and types of the programmable logic cell
// Assumes: 32-bit Avalon-MM register window, byte addressed
// Notes: each register has plain, clear, set and invert aliases
package plc_pkg;
  // register window: bits [5:4] pick the register, [3:2] the alias
  localparam int ADDR_W = 6;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_SEL = 2'h1;
  localparam logic [1:0] REG_GATE = 2'h2;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_SEL = 6'h10;
  localparam logic [5:0] OFF_GATE = 6'h20;
  localparam logic [1:0] ALIAS_PLAIN = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;

  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_GATE = 32'h0000_0000;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OUT_INV = 5;
  localparam int CTRL_STATUS = 6;
  localparam int CTRL_PIN_EN = 7;
  localparam int CTRL_FALL_IRQ = 10;
  localparam int CTRL_RISE_IRQ = 11;
  localparam int CTRL_ENABLE = 15;
  localparam int CTRL_GINV_LSB = 16;
  localparam logic [31:0] CTRL_WMASK = 32'h000f_8ca7;

  // input select: source n at bits 4n+2..4n
  localparam int SEL_STRIDE = 4;
  localparam logic [31:0] SEL_WMASK = 32'h0000_7777;

  // gate enable: gate g in byte g, inverted at 2d, true at 2d+1
  localparam int GATE_STRIDE = 8;
  localparam logic [31:0] GATE_WMASK = 32'hffff_ffff;

  typedef enum logic [2:0] {
    PLC_AND_OR,
    PLC_OR_XOR,
    PLC_AND4,
    PLC_SR_LATCH,
    PLC_DFF_SR,
    PLC_DFF2_R,
    PLC_JK_R,
    PLC_LATCH_SR
  } plc_mode_type;
endpackage

/* hw/plc_gate_array.sv */
// Purpose: four source multiplexers and four OR input gates
// Assumes: pool signals are on the same clock as the cell
// Notes: purely combinational
`timescale 1ns/10ps
module plc_gate_array #(
  parameter logic [159:0] SRC_MAP = {
    5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h18,
    5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10,
    5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
) (
  input wire logic [31:0] src_pool,
  input wire logic [31:0] sel_reg,
  input wire logic [31:0] gate_reg,
  input wire logic [3:0] gate_invert,
  output logic [3:0] gates
);
  logic [3:0] data_true;
  logic [7:0] cand;

  // one multiplexer per data input, eight sources each
  for (genvar p = 0; p < 4; p++) begin : g_mux
    logic [2:0] sel;
    logic [4:0] idx;
    assign sel = sel_reg[p*plc_pkg::SEL_STRIDE +: 3];
    assign idx = SRC_MAP[(p*8 + sel)*5 +: 5];
    assign data_true[p] = src_pool[idx];
    assign cand[2*p] = ~data_true[p];
    assign cand[2*p+1] = data_true[p];
  end

  // each gate ors its enabled candidates, then optional inversion
  for (genvar g = 0; g < 4; g++) begin : g_gate
    logic [7:0] en;
    assign en = gate_reg[g*plc_pkg::GATE_STRIDE +: 8];
    assign gates[g] = (|(cand & en)) ^ gate_invert[g];
  end
endmodule

/* hw/plc_logic_fn.sv */
// Purpose: the selectable logic function of the cell
// Assumes: gate signals are sampled on clk; flip-flop clock is gate 1
// Notes: storing modes show their state one cycle after the cause
`timescale 1ns/10ps
module plc_logic_fn (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire plc_pkg::plc_mode_type mode,
  input wire logic [3:0] gates,
  output logic fn_out
);
  logic q_ff;
  logic g1_prev_ff;
  logic nxt_q;
  logic g1_rise;

  assign g1_rise = gates[0] & ~g1_prev_ff;

  // previous gate 1 for clock edge detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      g1_prev_ff <= 1'b0;
    end else begin
      g1_prev_ff <= enable & gates[0];
    end
  end

  // next stored state per mode; reset wins over set
  always_comb begin
    nxt_q = q_ff;
    case (mode)
      plc_pkg::PLC_SR_LATCH: begin
        if (gates[2] | gates[3]) nxt_q = 1'b0;
        else if (gates[0] | gates[1]) nxt_q = 1'b1;
      end
      plc_pkg::PLC_DFF_SR: begin
        if (gates[2]) nxt_q = 1'b0;
        else if (gates[3]) nxt_q = 1'b1;
        else if (g1_rise) nxt_q = gates[1];
      end
      plc_pkg::PLC_DFF2_R: begin
        if (gates[2]) nxt_q = 1'b0;
        else if (g1_rise) nxt_q = gates[1] & gates[3];
      end
      plc_pkg::PLC_JK_R: begin
        if (gates[2]) nxt_q = 1'b0;
        else if (g1_rise) nxt_q = (gates[1] & ~q_ff) | (~gates[3] & q_ff);
      end
      plc_pkg::PLC_LATCH_SR: begin
        if (gates[2]) nxt_q = 1'b0;
        else if (gates[3]) nxt_q = 1'b1;
        else if (gates[0]) nxt_q = gates[1];
      end
      default: nxt_q = 1'b0;
    endcase
  end

  // stored state, cleared while disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= enable & nxt_q;
    end
  end

  // combinational modes answer at once, storing modes from state
  always_comb begin
    case (mode)
      plc_pkg::PLC_AND_OR: fn_out = (gates[0] & gates[1]) |
                                    (gates[2] & gates[3]);
      plc_pkg::PLC_OR_XOR: fn_out = (gates[0] | gates[1]) ^
                                    (gates[2] | gates[3]);
      plc_pkg::PLC_AND4: fn_out = &gates;
      default: fn_out = q_ff;
    endcase
  end

  chk_dff_reset: assert property (@(posedge clk) disable iff (sys_rst)
    mode == plc_pkg::PLC_DFF_SR && enable && gates[2] |=> !q_ff)
    else $error("d flip-flop reset did not clear state");
  cov_jk_toggle: cover property (@(posedge clk) disable iff (sys_rst)
    mode == plc_pkg::PLC_JK_R && enable && g1_rise ##1 $changed(q_ff));
endmodule

/* hw/plc_top.sv */
// Purpose: programmable logic cell with Avalon-MM register access
// Assumes: one 50 MHz clock; pool signals on that clock
// Notes: answers every access after exactly one wait cycle
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
// Overview of operation
// - four input gates feed the selected logic function
// - four multiplexers draw from a pool of 32 signals
// - each multiplexer picks one of eight by a three-bit field
// - input select register sets one source per multiplexer
// - each multiplexer offers its signal and its inverse
// - each gate ors the enabled true and inverted candidates
// - gate enable register: true and inverted bit per input, byte per gate
// - control holds module enable and rise and fall interrupt enables
// - control holds pin drive enable and final output inversion
// - three-bit function field selects the logic function
// - four bits invert each gate output separately
// - output goes to peripherals, pin, and a read-only status bit
// - cell evaluates continuously in hardware once enabled
// - all three registers reset to zero
// - disabled cell drives zero on its outputs, except one fall event pulse when a high output is disabled
// - function codes: and-or, or-xor, and4, sr, dff, dff2, jk, latch
// - interrupt event on rising or falling output edge when enabled
// - set gate inversion bit inverts that gate, clear passes it
module plc_top #(
  parameter logic [159:0] SRC_MAP = {
    5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h18,
    5'h17, 5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10,
    5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] src_pool,
  output logic cell_out,
  output logic pin_out,
  output logic pin_oe,
  output logic rise_event,
  output logic fall_event
);
  logic [31:0] ctrl_ff;
  logic [31:0] sel_ff;
  logic [31:0] gate_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] nxt_sel;
  logic [31:0] nxt_gate;
  logic [31:0] readdata_ff;
  logic [31:0] rd_word;
  logic ack_ff;
  logic req;
  logic wr_go;
  logic [1:0] reg_idx;
  logic [1:0] alias_op;
  logic [31:0] be_mask;
  logic [3:0] gates;
  logic fn_out;
  logic final_out;
  logic cell_out_ff;
  logic rise_ff;
  logic fall_ff;
  logic enable;
  logic out_inv;
  plc_pkg::plc_mode_type mode;

  // field views of the control register
  assign enable = ctrl_ff[plc_pkg::CTRL_ENABLE];
  assign out_inv = ctrl_ff[plc_pkg::CTRL_OUT_INV];
  assign mode = plc_pkg::plc_mode_type'(
    ctrl_ff[plc_pkg::CTRL_MODE_LSB +: 3]);

  // ---- bus slave ----
  // decode of register and alias
  assign req = avs_read | avs_write;
  assign reg_idx = avs_address[5:4];
  assign alias_op = avs_address[3:2];
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // one wait cycle for every access
  assign avs_waitrequest = req & ~ack_ff;
  assign wr_go = avs_write & ack_ff;
  assign avs_readdata = readdata_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // new register value from alias operation and lane mask
  function automatic logic [31:0] apply_wr(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] lanes,
    input logic [1:0] op,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = lanes & wmask;
    case (op)
      plc_pkg::ALIAS_CLR: apply_wr = old & ~(wd & m);
      plc_pkg::ALIAS_SET: apply_wr = old | (wd & m);
      plc_pkg::ALIAS_INV: apply_wr = old ^ (wd & m);
      default: apply_wr = (old & ~m) | (wd & m);
    endcase
  endfunction

  // next register values; unmapped index ignores writes
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_sel = sel_ff;
    nxt_gate = gate_ff;
    if (wr_go) begin
      case (reg_idx)
        plc_pkg::REG_CTRL: nxt_ctrl = apply_wr(ctrl_ff, avs_writedata,
          be_mask, alias_op, plc_pkg::CTRL_WMASK);
        plc_pkg::REG_SEL: nxt_sel = apply_wr(sel_ff, avs_writedata,
          be_mask, alias_op, plc_pkg::SEL_WMASK);
        plc_pkg::REG_GATE: nxt_gate = apply_wr(gate_ff, avs_writedata,
          be_mask, alias_op, plc_pkg::GATE_WMASK);
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  // control register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= plc_pkg::RST_CTRL;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // input select register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_ff <= plc_pkg::RST_SEL;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  // gate enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate_ff <= plc_pkg::RST_GATE;
    end else begin
      gate_ff <= nxt_gate;
    end
  end

  // read mux; status bit shows the live cell output
  always_comb begin
    case (reg_idx)
      plc_pkg::REG_CTRL: begin
        rd_word = ctrl_ff;
        rd_word[plc_pkg::CTRL_STATUS] = cell_out_ff;
      end
      plc_pkg::REG_SEL: rd_word = sel_ff;
      plc_pkg::REG_GATE: rd_word = gate_ff;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, held for the answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read & ~ack_ff) begin
      readdata_ff <= rd_word;
    end
  end

  // ---- cell datapath ----
  // multiplexers and input gates
  plc_gate_array #(
    .SRC_MAP(SRC_MAP)
  ) u_gates (
    .src_pool(src_pool),
    .sel_reg(sel_ff),
    .gate_reg(gate_ff),
    .gate_invert(ctrl_ff[plc_pkg::CTRL_GINV_LSB +: 4]),
    .gates(gates)
  );

  // selected logic function
  plc_logic_fn u_fn (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(enable),
    .mode(mode),
    .gates(gates),
    .fn_out(fn_out)
  );

  // final polarity, forced low while disabled
  assign final_out = enable & (fn_out ^ out_inv);

  // sampled cell output, evaluated every clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cell_out_ff <= 1'b0;
    end else begin
      cell_out_ff <= final_out;
    end
  end

  // edge events from current against previous sample
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= ctrl_ff[plc_pkg::CTRL_RISE_IRQ] &
                 final_out & ~cell_out_ff;
      fall_ff <= ctrl_ff[plc_pkg::CTRL_FALL_IRQ] &
                 ~final_out & cell_out_ff;
    end
  end

  // outputs to peripherals, pin and interrupt controller
  assign cell_out = cell_out_ff;
  assign pin_out = cell_out_ff;
  assign pin_oe = enable & ctrl_ff[plc_pkg::CTRL_PIN_EN];
  assign rise_event = rise_ff;
  assign fall_event = fall_ff;

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_bus_one_wait: assert property (
    req && !ack_ff |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");

  chk_disabled_low: assert property (
    !enable |=> !cell_out && !rise_event)
    else $error("disabled cell drove output high");

  chk_and_or_eval: assert property (
    enable && mode == plc_pkg::PLC_AND_OR |=>
    cell_out == $past((gates[0] & gates[1] |
                       gates[2] & gates[3]) ^ out_inv))
    else $error("and-or result wrong");

  chk_and4_invert: assert property (
    enable && mode == plc_pkg::PLC_AND4 && gates == 4'hf |=>
    cell_out == !$past(out_inv))
    else $error("output inversion wrong for all-high and4");

  chk_rise_cause: assert property (
    rise_event |-> cell_out && !$past(cell_out) &&
    $past(ctrl_ff[plc_pkg::CTRL_RISE_IRQ]))
    else $error("rise event without enabled rising edge");

  chk_fall_cause: assert property (
    fall_event |-> !cell_out && $past(cell_out) &&
    $past(ctrl_ff[plc_pkg::CTRL_FALL_IRQ]))
    else $error("fall event without enabled falling edge");

  chk_fall_gated: assert property (
    $fell(cell_out) && $past(ctrl_ff[plc_pkg::CTRL_FALL_IRQ]) |->
    fall_event)
    else $error("enabled falling edge gave no event");

  chk_status_mirror: assert property (
    avs_read && ack_ff && reg_idx == plc_pkg::REG_CTRL |->
    avs_readdata[plc_pkg::CTRL_STATUS] == $past(cell_out))
    else $error("status bit does not show the cell output");

  chk_sel_write_lands: assert property (
    wr_go && avs_address == plc_pkg::OFF_SEL &&
    avs_byteenable == 4'hf |=>
    sel_ff == ($past(avs_writedata) & plc_pkg::SEL_WMASK))
    else $error("input select write lost");

  chk_gate_off_zero: assert property (
    gate_ff[7:0] == 8'h00 && !ctrl_ff[plc_pkg::CTRL_GINV_LSB] |->
    !gates[0])
    else $error("gate with no enabled inputs is high");

  chk_reset_clear: assert property (
    $fell(sys_rst) |-> ctrl_ff == 32'h0000_0000 &&
    sel_ff == 32'h0000_0000 && gate_ff == 32'h0000_0000)
    else $error("registers not zero after reset");

  // status and reserved bits never stored by a write
  chk_ctrl_reserved: assert property (
    (ctrl_ff & ~plc_pkg::CTRL_WMASK) == 32'h0000_0000)
    else $error("read-only or reserved control bit was stored");

  cov_rise: cover property (rise_event);
  cov_fall: cover property (fall_event);
  cov_gate_write: cover property (
    wr_go && reg_idx == plc_pkg::REG_GATE);
  cov_pin_drive: cover property (pin_oe && pin_out);
endmodule

/* tb/plc_pool_model.sv */
// Purpose: far side of the cell, the pool of on-chip source signals
// Assumes: pool signals change on the cell clock, as the cell expects
// Notes: bench loads a new pool word; model also counts edge events
`timescale 1ns/10ps
module plc_pool_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [31:0] load_val,
  input wire logic rise_event,
  input wire logic fall_event,
  output logic [31:0] src_pool,
  output logic [7:0] edge_cnt
);
  logic [31:0] pool_ff;
  logic [7:0] cnt_ff;

  // pool word, launched on the clock edge like a real peripheral
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pool_ff <= 32'h0;
    end else if (load) begin
      pool_ff <= load_val;
    end
  end

  // interrupt controller side: tally of edge pulses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 8'h0;
    end else if (rise_event || fall_event) begin
      cnt_ff <= cnt_ff + 8'h1;
    end
  end

  assign src_pool = pool_ff;
  assign edge_cnt = cnt_ff;
endmodule

/* tb/programmable_logic_cell_tb.sv */
// Purpose: self-checking bench of the programmable logic cell
// Assumes: an access ends when waitrequest is sampled low
// Notes: corner cases first, then random combinational configurations, then byte lanes
`timescale 1ns/10ps
module programmable_logic_cell_tb;
  logic clk;
  logic sys_rst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] src_pool;
  logic cell_out;
  logic pin_out;
  logic pin_oe;
  logic rise_event;
  logic fall_event;
  logic pool_load;
  logic [31:0] pool_val;
  logic [7:0] edge_cnt;
  logic [31:0] rd;
  logic [31:0] sv, gv, cv, pv;
  logic e;
  int miscompares = 0;
  int checked = 0;
  int seed = 32'h3e92;

  plc_top plc_top_i (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .src_pool, .cell_out, .pin_out, .pin_oe, .rise_event, .fall_event);

  plc_pool_model plc_pool_model_i (.clk, .sys_rst, .load(pool_load),
    .load_val(pool_val), .rise_event, .fall_event, .src_pool, .edge_cnt);

  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // expected cell output for the combinational modes
  function automatic logic fexp(input logic [31:0] s, input logic [31:0] g,
      input logic [31:0] c, input logic [31:0] p);
    logic [3:0] d;
    logic [3:0] gt;
    logic [7:0] t;
    logic f;
    for (int i = 0; i < 4; i++) begin
      d[i] = p[i * 8 + s[i * 4 +: 3]];
      t[2 * i + 1] = d[i];
      t[2 * i] = ~d[i];
    end
    for (int k = 0; k < 4; k++) begin
      gt[k] = (|(g[k * 8 +: 8] & t)) ^ c[16 + k];
    end
    case (c[2:0])
      3'h0: f = (gt[0] & gt[1]) | (gt[2] & gt[3]);
      3'h1: f = (gt[0] | gt[1]) ^ (gt[2] | gt[3]);
      default: f = &gt;
    endcase
    return c[15] & (f ^ c[5]);
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask

  // one Avalon access, held until waitrequest is sampled low at a rise
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata; // taken at the answering edge
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic set_pool(input logic [31:0] v);
    @(posedge clk);
    pool_load <= 1'b1;
    pool_val <= v;
    @(posedge clk);
    pool_load <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    pool_load = 1'b0;
    pool_val = 32'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values and the unmapped slot
    for (int r = 0; r < 4; r++) begin
      bus(1'b0, 6'(r * 16), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    bus(1'b1, 6'h30, 32'hffff_ffff);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'hffff_7fff);
    bus(1'b0, plc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl mask", plc_pkg::CTRL_WMASK & 32'hffff_7fff, rd);
    bus(1'b0, 6'h30, 32'h0);
    chk("unmapped", 32'h0, rd);
    // plain, clear and invert aliases on input select
    bus(1'b1, plc_pkg::OFF_SEL, 32'hffff_1234);
    bus(1'b1, plc_pkg::OFF_SEL + 6'h4, 32'h0000_0004);
    bus(1'b1, plc_pkg::OFF_SEL + 6'hc, 32'h0000_0011);
    bus(1'b0, plc_pkg::OFF_SEL, 32'h0);
    chk("sel alias", 32'h0000_1221, rd);
    // edge events: cell follows pool bit 0, gate 2 forced high
    bus(1'b1, plc_pkg::OFF_SEL, 32'h0);
    bus(1'b1, plc_pkg::OFF_GATE, 32'h0000_0002);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0002_8c80);
    set_pool(32'h1);
    settle(1);
    chk("rise cell_out", 32'h1, cell_out);
    chk("rise event", 32'h1, rise_event);
    chk("no fall event", 32'h0, fall_event);
    settle(0);
    chk("rise pulse end", 32'h0, rise_event);
    set_pool(32'h0);
    settle(1);
    chk("fall event", 32'h1, fall_event);
    chk("pin data", 32'h0, pin_out);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0002_8080);
    set_pool(32'h1);
    settle(1);
    chk("masked rise", 32'h0, rise_event);
    chk("edge count", 32'h2, edge_cnt);
    // sr latch: set by gate 1, reset by gate 3, holds between
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0);
    set_pool(32'h0);
    bus(1'b1, plc_pkg::OFF_GATE, 32'h0008_0002);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0000_8003);
    settle(2);
    chk("sr idle", 32'h0, cell_out);
    set_pool(32'h1);
    settle(2);
    chk("sr set", 32'h1, cell_out);
    set_pool(32'h0);
    settle(2);
    chk("sr hold", 32'h1, cell_out);
    set_pool(32'h100);
    settle(2);
    chk("sr reset", 32'h0, cell_out);
    // disabled cell drives zero even when its state would be one
    set_pool(32'h1);
    settle(2);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0000_00a3);
    settle(2);
    chk("disabled out", 32'h0, cell_out);
    chk("disabled oe", 32'h0, pin_oe);
    // storing modes with quiet gates keep a cleared state
    bus(1'b1, plc_pkg::OFF_GATE, 32'h0);
    for (int m = 3; m < 8; m++) begin
      bus(1'b1, plc_pkg::OFF_CTRL, 32'h0000_8020 | 32'(m));
      settle(2);
      chk("store mode", 32'h1, cell_out);
    end
    // d flip-flop: gate 1 clocks from pool bit 0, gate 2 is pool bit 8
    bus(1'b1, plc_pkg::OFF_GATE, 32'h0000_0802);
    bus(1'b1, plc_pkg::OFF_CTRL, 32'h0000_8004);
    set_pool(32'h100);
    settle(2);
    chk("dff no edge", 32'h0, cell_out);
    set_pool(32'h101);
    settle(2);
    chk("dff capture", 32'h1, cell_out);
    set_pool(32'h001);
    settle(2);
    chk("dff hold", 32'h1, cell_out);
    // random combinational configurations
    for (int n = 0; n < 60; n++) begin
      sv = $random(seed) & plc_pkg::SEL_WMASK;
      gv = $random(seed);
      cv = ($random(seed) & 32'h000f_8ca0) | 32'($unsigned($random(seed)) % 3);
      pv = $random(seed);
      if (n < 4) cv[15] = 1'b1;
      e = fexp(sv, gv, cv, pv);
      bus(1'b1, plc_pkg::OFF_SEL, sv);
      bus(1'b1, plc_pkg::OFF_GATE, gv);
      bus(1'b1, plc_pkg::OFF_CTRL, cv);
      set_pool(pv);
      settle(2);
      chk("cell_out", 32'(e), cell_out);
      chk("pin_out", 32'(e), pin_out);
      chk("pin_oe", 32'(cv[15] & cv[7]), pin_oe);
      bus(1'b0, plc_pkg::OFF_CTRL, 32'h0);
      chk("ctrl status", cv | (32'(e) << 6), rd);
      bus(1'b0, plc_pkg::OFF_GATE, 32'h0);
      chk("gate readback", gv, rd);
    end
    // byte lanes: set alias through lane 1 only
    bus(1'b1, plc_pkg::OFF_GATE, 32'h0);
    avs_byteenable <= 4'h2;
    bus(1'b1, plc_pkg::OFF_GATE + 6'h8, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    bus(1'b0, plc_pkg::OFF_GATE, 32'h0);
    chk("byte lanes", 32'h0000_ff00, rd);
    close_out();
  end
endmodule
